// File: bench/tb.sv
// self-checking bench for the quad serial pin-signalling block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cs_n = 1'b1;
  logic       rw = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic [3:0] tx_ser = 4'h0;
  logic [3:0] tx_en = 4'h0;
  logic [3:0] below = 4'h0;
  logic [3:0] avail = 4'h0;
  logic [3:0] space = 4'h0;
  logic       go = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] rd;
  int         errors = 0;
  int         checks_done = 0;
  wire  [3:0] ser_in;
  wire  [7:0] rdata;
  wire        oe;
  wire  [3:0] ser_out;
  wire  [3:0] rx_core;
  wire  [3:0] loop;
  wire  [3:0] rts_n;
  wire        rx_sum;
  wire        tx_sum;
  always #4 clk = ~clk;
  uqps_top i_uqps_top (.CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .RW_I(rw),
    .ADDR_I(addr), .DATA_I(wdata), .DATA_O(rdata), .DATA_OE_O(oe),
    .TX_SER_I(tx_ser), .TX_EN_I(tx_en), .RX_BELOW_TRIG_I(below),
    .RX_AVAIL_I(avail), .TX_SPACE_I(space), .SER_IN_I(ser_in),
    .SER_OUT_O(ser_out), .RX_CORE_O(rx_core), .LOOP_O(loop),
    .REQ_SEND_N_O(rts_n), .RX_READY_SUM_N_O(rx_sum),
    .TX_SPACE_SUM_N_O(tx_sum));
  uqps_peer i_uqps_peer (.clk_i(clk), .rst_i(rst), .start_i(go),
    .sel_i(sel), .byte_i(8'h00), .line_o(ser_in));
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // pins held well past the two-flop synchroniser delay
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    cs_n = 1'b0;
    rw = 1'b0;
    addr = a;
    wdata = d;
    cyc(4);
    cs_n = 1'b1;
    cyc(4);
  endtask
  task automatic bus_rd(input logic [4:0] a, output logic [7:0] d);
    cs_n = 1'b0;
    rw = 1'b1;
    addr = a;
    cyc(4);
    d = rdata;
    check("bus drive", {7'h00, oe}, 8'h01);
    cs_n = 1'b1;
    cyc(5);
    check("bus release", {7'h00, oe}, 8'h00);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // run takes about 235 cycles
  initial
  begin
    #200000;
    errors++;
    close_out();
  end
  initial
  begin
    cyc(10);
    rst = 1'b0;
    cyc(2);
    check("rts", {4'h0, rts_n}, 8'h0f);
    check("tx pin", {4'h0, ser_out}, 8'h0f);
    // request-to-send on each channel in turn, read back
    for (int ch = 0; ch < 4; ch++)
    begin
      bus_wr({2'(ch), uqps_pkg::REG_MODEM_CTL}, 8'h02);
      check("rts", {4'h0, rts_n}, {4'h0, 4'(4'hf << (ch + 1))});
      bus_rd({2'(ch), uqps_pkg::REG_MODEM_CTL}, rd);
      check("modem ctl", rd, 8'h02);
    end
    // auto mode on channel a gates on receive room
    bus_wr({2'h0, uqps_pkg::REG_ENH_FEAT}, 8'h40);
    check("rts auto", {4'h0, rts_n}, 8'h01);
    below = 4'h1;
    cyc(1);
    check("rts auto", {4'h0, rts_n}, 8'h00);
    bus_wr({2'h0, uqps_pkg::REG_MODEM_CTL}, 8'h00);
    check("rts off", {4'h0, rts_n}, 8'h01);
    // transmit pin follows data only while enabled
    tx_en = 4'hf;
    for (int v = 3; v < 15; v += 5)
    begin
      tx_ser = 4'(v);
      cyc(1);
      check("tx pin", {4'h0, ser_out}, 8'(v));
    end
    tx_en = 4'h0;
    cyc(1);
    check("tx idle", {4'h0, ser_out}, 8'h0f);
    // loop-back on channel c only
    bus_wr({2'h2, uqps_pkg::REG_MODEM_CTL}, 8'h10);
    check("loop", {4'h0, loop}, 8'h04);
    tx_en = 4'hf;
    tx_ser = 4'hb;
    cyc(1);
    check("tx loop", {4'h0, ser_out}, 8'h0f);
    check("rx loop", {4'h0, rx_core}, 8'h0b);
    tx_ser = 4'h4;
    sel = 4'hf;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(3);
    check("rx frame", {4'h0, rx_core}, 8'h04);
    cyc(40);
    check("rx idle", {4'h0, rx_core}, 8'h0f);
    bus_wr({2'h2, uqps_pkg::REG_MODEM_CTL}, 8'h00);
    // summaries over every flag pattern
    for (int v = 0; v < 16; v++)
    begin
      avail = 4'(v);
      space = 4'(v) ^ 4'h6;
      cyc(1);
      check("rx sum", {7'h00, rx_sum}, {7'h00, avail == 4'h0});
      check("tx sum", {7'h00, tx_sum}, {7'h00, space == 4'h0});
    end
    // per-channel status through the line status offset
    avail = 4'h5;
    space = 4'h9;
    for (int ch = 0; ch < 4; ch++)
    begin
      bus_rd({2'(ch), uqps_pkg::REG_LINE_STAT}, rd);
      check("lsr", rd, {2'h0, space[ch], 4'h0, avail[ch]});
    end
    bus_rd({2'h1, 3'h7}, rd);
    check("unmapped", rd, 8'h00);
    // second reset in mid-run
    rst = 1'b1;
    cyc(2);
    check("rts", {4'h0, rts_n}, 8'h0f);
    check("loop", {4'h0, loop}, 8'h00);
    rst = 1'b0;
    cyc(2);
    bus_wr({2'h1, uqps_pkg::REG_MODEM_CTL}, 8'h02);
    check("rts after reset", {4'h0, rts_n}, 8'h0d);
    close_out();
  end
endmodule
`default_nettype wire

// File: bench/uqps_peer.sv
// serial line peer: sends one frame on the selected receive lines
`timescale 1ns/100ps
`default_nettype none
module uqps_peer
#(
  parameter int unsigned BIT_CYC = 4
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [7:0] byte_i,
  output logic      [3:0] line_o
);
  logic [9:0] frame_r;
  logic [3:0] bits_r;
  logic [7:0] cyc_r;
  // start bit, byte lsb first, stop bit; all ones once shifted out
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frame_r <= 10'h3ff;
      bits_r  <= 4'h0;
      cyc_r   <= 8'h00;
    end
    else if (start_i && bits_r == 4'h0)
    begin
      frame_r <= {1'b1, byte_i, 1'b0};
      bits_r  <= 4'ha;
      cyc_r   <= 8'h00;
    end
    else if (bits_r != 4'h0 && cyc_r == 8'(BIT_CYC - 1))
    begin
      frame_r <= {1'b1, frame_r[9:1]};
      bits_r  <= bits_r - 4'h1;
      cyc_r   <= 8'h00;
    end
    else if (bits_r != 4'h0)
      cyc_r <= cyc_r + 8'h01;
  end
  // unselected lines and idle time stay high
  assign line_o = ~(sel_i & {4{~frame_r[0]}});
endmodule
`default_nettype wire

// File: pkg/uqps_pkg.sv
// constants for the quad serial pin-signalling block
package uqps_pkg;
  localparam int unsigned NUM_CH        = 4;
  // register offsets on address lines 2..0
  localparam logic [2:0]  REG_ENH_FEAT  = 3'h2;
  localparam logic [2:0]  REG_MODEM_CTL = 3'h4;
  localparam logic [2:0]  REG_LINE_STAT = 3'h5;
  // field positions
  localparam int unsigned MODEM_RTS_BIT    = 1;
  localparam int unsigned MODEM_LOOP_BIT   = 4;
  localparam int unsigned ENH_AUTO_RTS_BIT = 6;
  localparam int unsigned LSR_RX_BIT    = 0;
  localparam int unsigned LSR_TX_BIT    = 5;
  // address field positions
  localparam int unsigned CH_ADDR_LSB   = 3;
  // reset values
  localparam logic [7:0]  MODEM_CTL_RST = 8'h00;
  localparam logic [7:0]  ENH_FEAT_RST  = 8'h00;
  // synchroniser layout: {rx[3:0], data[7:0], addr[4:0], rw, cs_n}
  localparam int unsigned SYNC_W        = 19;
  localparam logic [18:0] SYNC_RST      = 19'h78001;
endpackage

// File: verilog/uqps_chan.sv
// one channel: control registers, request-to-send and serial pin routing
`timescale 1ns/100ps
`default_nettype none
module uqps_chan
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_stb_i,
  input  wire logic [2:0] reg_sel_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       tx_ser_i,
  input  wire logic       tx_en_i,
  input  wire logic       rx_pin_i,
  input  wire logic       rx_below_trig_i,
  input  wire logic       rx_avail_i,
  input  wire logic       tx_space_i,
  output logic      [7:0] rdata_o,
  output logic            rts_n_o,
  output logic            ser_out_o,
  output logic            rx_core_o,
  output logic            loop_o
);
  logic [7:0] modem_ctrl_r;
  logic [7:0] modem_ctrl_nxt;
  logic [7:0] enh_feat_r;
  logic [7:0] enh_feat_nxt;
  logic       ser_r;
  logic       ser_nxt;

  // register writes; offsets outside the map are ignored
  always_comb
  begin
    modem_ctrl_nxt = modem_ctrl_r;
    enh_feat_nxt   = enh_feat_r;
    if (wr_stb_i && reg_sel_i == uqps_pkg::REG_MODEM_CTL)
      modem_ctrl_nxt = wdata_i;
    if (wr_stb_i && reg_sel_i == uqps_pkg::REG_ENH_FEAT)
      enh_feat_nxt = wdata_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      modem_ctrl_r <= uqps_pkg::MODEM_CTL_RST;
      enh_feat_r   <= uqps_pkg::ENH_FEAT_RST;
    end
    else
    begin
      modem_ctrl_r <= modem_ctrl_nxt;
      enh_feat_r   <= enh_feat_nxt;
    end
  end

  assign loop_o = modem_ctrl_r[uqps_pkg::MODEM_LOOP_BIT];

  // low means data waiting; auto mode also needs room in the receiver,
  // otherwise the flag plays no part in the data path
  // reset clears the control bit, so the pin idles high
  assign rts_n_o = ~(modem_ctrl_r[uqps_pkg::MODEM_RTS_BIT]
                   & (~enh_feat_r[uqps_pkg::ENH_AUTO_RTS_BIT]
                      | rx_below_trig_i));

  // line held high when idle, disabled or looped back
  always_comb
  begin
    ser_nxt = tx_ser_i;
    if (loop_o || !tx_en_i)
      ser_nxt = 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ser_r <= 1'b1;
    else
      ser_r <= ser_nxt;
  end

  assign ser_out_o = ser_r;

  // loop-back feeds own transmit data, external pin ignored
  assign rx_core_o = loop_o ? tx_ser_i : rx_pin_i;

  // readback of control and per-channel status
  always_comb
  begin
    rdata_o = 8'h00;
    unique case (reg_sel_i)
      uqps_pkg::REG_MODEM_CTL: rdata_o = modem_ctrl_r;
      uqps_pkg::REG_ENH_FEAT:  rdata_o = enh_feat_r;
      uqps_pkg::REG_LINE_STAT:
      begin
        rdata_o[uqps_pkg::LSR_RX_BIT] = rx_avail_i;
        rdata_o[uqps_pkg::LSR_TX_BIT] = tx_space_i;
      end
      default: rdata_o = 8'h00;
    endcase
  end

  // control write with bit 1 set and auto mode off lowers the pin
  property p_rts_set;
    @(posedge clk_i) disable iff (rst_i)
    (wr_stb_i && reg_sel_i == uqps_pkg::REG_MODEM_CTL
     && wdata_i[uqps_pkg::MODEM_RTS_BIT]
     && !enh_feat_r[uqps_pkg::ENH_AUTO_RTS_BIT]) |=> !rts_n_o;
  endproperty
  a_rts_set: assert property (p_rts_set)
    else $error("request-to-send not low after control write");
endmodule
`default_nettype wire

// File: verilog/uqps_top.sv
// four-channel serial pin signalling with combined-strobe host bus
// Overview of operation
// - each channel's request-to-send pin goes low when data waits.
// - writing one to modem control bit 1 drives request-to-send low, in auto mode only while below the receive trigger.
// - after reset every request-to-send pin is high.
// - request-to-send affects data flow only with auto mode (bit 6).
// - the combined strobe reads when high and writes when low.
// - each transmit pin is high in reset, when idle and when disabled.
// - loop-back ignores the receive pin and feeds own transmit data in.
// - loop-back disables the transmit pin, holding it high.
// - receive summary goes low when any channel has data available.
// - receive summary returns high when no channel has data left.
// - transmit summary is low while any channel has a free location.
// - transmit summary is high only when all channels are full.
// - per-channel status is read through chip select and address.
// - address lines 4..3 pick the channel, 00 A to 11 D.
`timescale 1ns/100ps
`default_nettype none
module uqps_top
(
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       CS_N_I,
  input  wire logic       RW_I,
  input  wire logic [4:0] ADDR_I,
  input  wire logic [7:0] DATA_I,
  output logic      [7:0] DATA_O,
  output logic            DATA_OE_O,
  input  wire logic [3:0] TX_SER_I,
  input  wire logic [3:0] TX_EN_I,
  input  wire logic [3:0] RX_BELOW_TRIG_I,
  input  wire logic [3:0] RX_AVAIL_I,
  input  wire logic [3:0] TX_SPACE_I,
  input  wire logic [3:0] SER_IN_I,
  output logic      [3:0] SER_OUT_O,
  output logic      [3:0] RX_CORE_O,
  output logic      [3:0] LOOP_O,
  output logic      [3:0] REQ_SEND_N_O,
  output logic            RX_READY_SUM_N_O,
  output logic            TX_SPACE_SUM_N_O
);
  typedef enum logic [0:0] {BUS_IDLE, BUS_HOLD} uqps_bus_t;

  uqps_bus_t   st_r;
  uqps_bus_t   st_nxt;
  logic [18:0] sync1_r;
  logic [18:0] sync2_r;
  logic        cs_n_s;
  logic        rw_s;
  logic [4:0]  addr_s;
  logic [7:0]  data_s;
  logic [3:0]  rx_s;
  logic        take;
  logic [1:0]  chan_sel;
  logic [3:0]  wr_stb;
  logic [7:0]  rdata_ch [4];
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        oe_r;
  logic        oe_nxt;

  // channel number from the upper address pair
  function automatic logic [1:0] chan_of(input logic [4:0] a);
    chan_of = a[uqps_pkg::CH_ADDR_LSB +: 2];
  endfunction

  // two-stage synchroniser; receive lines reset high as the far side idles
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      sync1_r <= uqps_pkg::SYNC_RST;
      sync2_r <= uqps_pkg::SYNC_RST;
    end
    else
    begin
      sync1_r <= {SER_IN_I, DATA_I, ADDR_I, RW_I, CS_N_I};
      sync2_r <= sync1_r;
    end
  end

  assign cs_n_s = sync2_r[0];
  assign rw_s   = sync2_r[1];
  assign addr_s = sync2_r[6:2];
  assign data_s = sync2_r[14:7];
  assign rx_s   = sync2_r[18:15];

  // one access per chip-select assertion; waits for release before the next
  assign take     = (st_r == BUS_IDLE) && !cs_n_s;
  assign chan_sel = chan_of(addr_s);

  // write only with the strobe low, to the decoded channel
  always_comb
  begin
    wr_stb = 4'h0;
    if (take && !rw_s)
      wr_stb[chan_sel] = 1'b1;
  end

  // bus state, read data and data-bus enable
  always_comb
  begin
    st_nxt    = st_r;
    rdata_nxt = rdata_r;
    oe_nxt    = oe_r;
    unique case (st_r)
      BUS_IDLE:
        if (take)
        begin
          st_nxt = BUS_HOLD;
          if (rw_s)
          begin
            rdata_nxt = rdata_ch[chan_sel];
            oe_nxt    = 1'b1;
          end
        end
      BUS_HOLD:
        if (cs_n_s)
        begin
          st_nxt = BUS_IDLE;
          oe_nxt = 1'b0;
        end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      st_r    <= BUS_IDLE;
      rdata_r <= 8'h00;
      oe_r    <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      rdata_r <= rdata_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign DATA_O    = rdata_r;
  assign DATA_OE_O = oe_r;

  // the four channel blocks
  for (genvar g = 0; g < 4; g++)
  begin : g_ch
    uqps_chan u_chan
    (
      .clk_i           (CLK_I),
      .rst_i           (RST_I),
      .wr_stb_i        (wr_stb[g]),
      .reg_sel_i       (addr_s[2:0]),
      .wdata_i         (data_s),
      .tx_ser_i        (TX_SER_I[g]),
      .tx_en_i         (TX_EN_I[g]),
      .rx_pin_i        (rx_s[g]),
      .rx_below_trig_i (RX_BELOW_TRIG_I[g]),
      .rx_avail_i      (RX_AVAIL_I[g]),
      .tx_space_i      (TX_SPACE_I[g]),
      .rdata_o         (rdata_ch[g]),
      .rts_n_o         (REQ_SEND_N_O[g]),
      .ser_out_o       (SER_OUT_O[g]),
      .rx_core_o       (RX_CORE_O[g]),
      .loop_o          (LOOP_O[g])
    );
  end

  // combinational summaries so a DMA engine sees status without delay
  assign RX_READY_SUM_N_O = ~|RX_AVAIL_I;
  assign TX_SPACE_SUM_N_O = ~|TX_SPACE_I;

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  property p_rts_clear;
    (wr_stb != 4'h0 && addr_s[2:0] == uqps_pkg::REG_MODEM_CTL
     && !data_s[uqps_pkg::MODEM_RTS_BIT]) |=> REQ_SEND_N_O[$past(chan_sel)];
  endproperty
  a_rts_clear: assert property (p_rts_clear)
    else $error("request-to-send low without control bit");

  property p_rts_rst;
    @(posedge CLK_I) $fell(RST_I) |-> REQ_SEND_N_O == 4'hf;
  endproperty
  a_rts_rst: assert property (p_rts_rst)
    else $error("request-to-send not high after reset");

  property p_loop_tx;
    LOOP_O != 4'h0 |=> (SER_OUT_O & $past(LOOP_O)) == $past(LOOP_O);
  endproperty
  a_loop_tx: assert property (p_loop_tx)
    else $error("transmit pin driven in loop-back");

  property p_loop_rx;
    LOOP_O != 4'h0 |-> (RX_CORE_O & LOOP_O) == (TX_SER_I & LOOP_O);
  endproperty
  a_loop_rx: assert property (p_loop_rx)
    else $error("receiver not fed from own transmitter in loop-back");

  property p_tx_idle;
    !TX_EN_I[2] |=> SER_OUT_O[2];
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("transmit pin low while disabled");

  property p_rx_sum;
    RX_READY_SUM_N_O == (RX_AVAIL_I == 4'h0);
  endproperty
  a_rx_sum: assert property (p_rx_sum)
    else $error("receive summary wrong");

  property p_tx_sum;
    TX_SPACE_SUM_N_O == (TX_SPACE_I == 4'h0);
  endproperty
  a_tx_sum: assert property (p_tx_sum)
    else $error("transmit summary wrong");

  property p_read_oe;
    (take && rw_s) |=> DATA_OE_O && DATA_O == $past(rdata_ch[chan_sel]);
  endproperty
  a_read_oe: assert property (p_read_oe)
    else $error("read did not present channel data");

  property p_no_write_on_read;
    rw_s |-> wr_stb == 4'h0;
  endproperty
  a_no_write_on_read: assert property (p_no_write_on_read)
    else $error("write strobe during read");

  property p_chan_dec;
    (take && !rw_s) |-> wr_stb == (4'h1 << addr_s[4:3]);
  endproperty
  a_chan_dec: assert property (p_chan_dec)
    else $error("wrong channel selected");

  c_write: cover property (take && !rw_s);
  c_read: cover property (take && rw_s ##1 DATA_OE_O);
  c_loop: cover property (LOOP_O[2] && !TX_SER_I[2]);
  c_full: cover property (!TX_SPACE_SUM_N_O ##1 TX_SPACE_SUM_N_O);
endmodule
`default_nettype wire
